// *** core/dss_span_step.sv ***
/*
 * Control logic of a 12-bit voltage DAC: span decode, pin stepping,
 * clear, buffer enable, ready delay and SPI slave framing.
 * Assumes pins arrive asynchronously and the nonvolatile array is outside.
 */
`timescale 1ns/1ps
`include "dss_cfg.svh"

module dss_span_step #(
	parameter int RDY_CYCLES = `DSS_RDY_DELAY_US *
		(`DSS_CLK_HZ / `DSS_HZ_PER_MHZ)
) (
	input  wire logic               clock_i,            // 40 MHz clock
	input  wire logic               resetn_i,           // Sync reset, low
	input  wire logic               cs_n_i,             // Chip select, low
	input  wire logic               sck_i,              // Serial clock
	input  wire logic               si_i,               // Serial data in
	output logic                    so_o,               // Serial data out
	output logic                    so_oe_o,            // Serial out enable
	input  wire logic               up_i,               // Step up pin
	input  wire logic               down_i,             // Step down pin
	input  wire logic               async_zero_pin_i,   // Async clear, high
	input  wire logic               buf_oe_i,           // Buffer enable
	input  wire logic               supply_ok_i,        // Supply above trip
	output logic                    ready_n_o,          // Ready, open drain
	output logic                    ready_n_oe_o,       // Ready pull low
	input  wire logic [7:0]         nv_image_i,         // Stored config
	output logic                    nv_write_o,         // Storage write
	output logic [5:0]              nv_addr_o,          // Storage address
	output logic [7:0]              nv_data_o,          // Storage data
	output logic [11:0]             dac_code_o,         // DAC code
	output dss_pkg::dss_scale_s     full_scale_level_o, // Full scale
	output dss_pkg::dss_scale_s     zero_scale_level_o, // Zero scale
	output logic                    buffer_drive_o      // Buffer drives
);
	import dss_pkg::*;

	localparam int CW = $clog2(RDY_CYCLES + 1);

	// Decode one scale field into source enable and level
	function automatic dss_scale_s scale_dec(input logic [2:0] sel,
			input logic zero_side);
		dss_scale_s r;
		logic [11:0] k;
		k = zero_side ? {9'h000, sel - 3'h1} : {9'h000, sel};
		r.int_en = (sel != `DSS_SEL_EXT) && (sel <= `DSS_SEL_MAX);
		if (!r.int_en)
			r.level_mv = 12'h000;
		else if (zero_side && sel == `DSS_SEL_ZS_LOW)
			r.level_mv = `DSS_ZS_LOW_MV;
		else
			r.level_mv = 12'(k * `DSS_STEP_MV);
		return r;
	endfunction : scale_dec

	logic [`DSS_NPIN-1:0] s1, s2, s3, filt, filt_d;
	logic                 not_ready;
	logic [CW-1:0]        rdy_cnt;
	logic [7:0]           cfg;
	logic                 cfg_loaded;
	logic                 persist_target_sel;
	logic [11:0]          dac;
	logic [7:0]           shreg, hi_hold, tx_byte;
	logic [2:0]           bit_cnt;
	logic                 rw;
	logic [5:0]           ptr;
	dss_spi_e             st;
	dss_scale_s           fs_q, zs_q;

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			{s1, s2, s3, filt, filt_d} <= {5{`DSS_PIN_IDLE}};
		end else begin
			s1 <= {supply_ok_i, buf_oe_i, down_i, up_i, si_i, sck_i, cs_n_i};
			s2 <= s1;
			s3 <= s2;
			filt <= (s3 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
			filt_d <= filt;
		end
	end

	// Edge and level decode of filtered pins
	wire cs_hi    = filt[`DSS_P_CS];
	wire si       = filt[`DSS_P_SI];
	wire sck_rise = filt[`DSS_P_SCK] & ~filt_d[`DSS_P_SCK];
	wire sck_fall = ~filt[`DSS_P_SCK] & filt_d[`DSS_P_SCK];
	wire up_fall  = filt_d[`DSS_P_UP] & ~filt[`DSS_P_UP];
	wire dn_fall  = filt_d[`DSS_P_DN] & ~filt[`DSS_P_DN];
	// sampling needs select and ready low
	wire spi_on   = ~cs_hi & ~not_ready;
	wire clr_gate = async_zero_pin_i & ~not_ready;

	wire [1:0]  gran     = cfg[`DSS_GR_MSB:`DSS_GR_LSB];
	// step weight keeps low bits intact
	wire [11:0] step_amt = (gran == `DSS_GR_10) ? `DSS_STEP_10 :
		(gran == `DSS_GR_8) ? `DSS_STEP_8 : `DSS_STEP_12;
	// stepping only in standby, never reserved
	wire step_ok  = cs_hi & (gran != `DSS_GR_RSV);
	wire do_inc   = step_ok & up_fall & ~filt[`DSS_P_DN];
	wire do_dec   = step_ok & dn_fall & ~filt[`DSS_P_UP];

	// Serial byte decode
	wire [7:0] rx_byte   = {shreg[6:0], si};
	wire       byte_done = spi_on & sck_rise & (bit_cnt == `DSS_BIT_LAST);
	wire       addr_ok   = (rx_byte[7:6] == 2'h0);
	wire       data_wr   = byte_done & (st == SP_DATA) & ~rw;
	wire       ptr_dac   = (ptr == `DSS_A_DAC_HI) | (ptr == `DSS_A_DAC_LO);
	// persist bit routes DAC writes to storage
	wire dac_wr_vol = data_wr & (ptr == `DSS_A_DAC_LO) & ~persist_target_sel;
	// config writes always go to storage
	wire nv_wr = data_wr & ((ptr == `DSS_A_CFG) |
		(persist_target_sel & ptr_dac));
	wire rd_load = byte_done & rw &
		(((st == SP_ADDR) & addr_ok) | (st == SP_DATA));
	wire [5:0] rd_addr = (st == SP_ADDR) ? rx_byte[5:0] : ptr;
	wire [7:0] rd_data =
		(rd_addr == `DSS_A_DAC_HI)  ? dac[11:4] :
		(rd_addr == `DSS_A_DAC_LO)  ? {dac[3:0], 4'h0} :
		(rd_addr == `DSS_A_CFG)     ? cfg :
		(rd_addr == `DSS_A_PERSIST) ? {persist_target_sel, 7'h00} : 8'h00;

	// ready delay after supply, back high on drop
	always_ff @(posedge clock_i) begin
		if (!resetn_i || !filt[`DSS_P_SUP])
			{not_ready, rdy_cnt} <= {1'b1, CW'(0)};
		else if (not_ready) begin
			if (rdy_cnt == CW'(RDY_CYCLES - 1))
				not_ready <= 1'b0;
			else
				rdy_cnt <= rdy_cnt + 1'b1;
		end
	end

	// config restored from storage after reset
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			cfg <= `DSS_CFG_RESET;
			cfg_loaded <= 1'b0;
		end else if (!cfg_loaded) begin
			cfg <= nv_image_i;
			cfg_loaded <= 1'b1;
		end else if (data_wr && ptr == `DSS_A_CFG)
			cfg <= rx_byte;
	end

	// persist bit set by 80h, cleared by 00h
	always_ff @(posedge clock_i) begin
		if (!resetn_i)
			persist_target_sel <= 1'b0;
		else if (data_wr && ptr == `DSS_A_PERSIST &&
				(rx_byte | `DSS_PERSIST_SET) == `DSS_PERSIST_SET)
			persist_target_sel <= (rx_byte == `DSS_PERSIST_SET);
	end

	// Storage write strobe with address and data
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			{nv_write_o, nv_addr_o, nv_data_o} <= 15'h0000;
		end else begin
			nv_write_o <= nv_wr;
			if (nv_wr) begin
				nv_addr_o <= ptr;
				nv_data_o <= rx_byte;
			end
		end
	end

	// shifted in most significant bit first
	always_ff @(posedge clock_i or posedge clr_gate) begin
		if (clr_gate) begin
			{shreg, hi_hold} <= 16'h0000;
		end else if (!resetn_i) begin
			{shreg, hi_hold} <= 16'h0000;
		end else if (spi_on && sck_rise) begin
			shreg <= rx_byte;
			if (data_wr && ptr == `DSS_A_DAC_HI)
				hi_hold <= rx_byte;
		end
	end

	// slave framing, reset by each deselect
	always_ff @(posedge clock_i) begin
		if (!resetn_i || cs_hi) begin
			st <= SP_ID;
			{bit_cnt, rw, ptr} <= 10'h000;
		end else if (spi_on && sck_rise) begin
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == `DSS_BIT_LAST) begin
				case (st)
					SP_ID: begin
						rw <= si;
						st <= SP_ADDR;
					end
					SP_ADDR: begin
						st <= addr_ok ? SP_DATA : SP_SKIP;
						ptr <= rw ? rx_byte[5:0] + 6'h01 : rx_byte[5:0];
					end
					SP_DATA:
						ptr <= rw ? ptr + 6'h01 : {ptr[5:3], ptr[2:0] + 3'h1};
					default: st <= SP_SKIP;
				endcase
			end
		end
	end

	// read data shifted out on falling serial clock
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			{tx_byte, so_o, so_oe_o} <= 10'h000;
		end else if (cs_hi)
			so_oe_o <= 1'b0;
		else begin
			if (rd_load) begin
				tx_byte <= rd_data;
				so_oe_o <= 1'b1;
			end
			if (spi_on && sck_fall && so_oe_o)
				so_o <= tx_byte[`DSS_BIT_LAST - bit_cnt];
		end
	end

	// one step per cycle, far above 500kHz pulses
	wire [11:0] next_dac = dac_wr_vol ? {hi_hold, rx_byte[7:4]} :
		do_inc ? dac + step_amt : do_dec ? dac - step_amt : dac;

	always_ff @(posedge clock_i or posedge clr_gate) begin
		if (clr_gate)
			dac <= `DSS_DAC_ZERO;
		else if (!resetn_i)
			dac <= `DSS_DAC_ZERO;
		else
			dac <= next_dac;
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			{fs_q, zs_q, buffer_drive_o} <= 27'h0000000;
		end else begin
			fs_q <= scale_dec(cfg[`DSS_FS_MSB:`DSS_FS_LSB], 1'b0);
			zs_q <= scale_dec(cfg[`DSS_ZS_MSB:`DSS_ZS_LSB], 1'b1);
			buffer_drive_o <= filt[`DSS_P_OE];
		end
	end

	assign full_scale_level_o = fs_q;
	assign zero_scale_level_o = zs_q;
	assign dac_code_o = dac;
	assign ready_n_o = 1'b0;
	assign ready_n_oe_o = ~not_ready;

	// Checks on stepping, span, ready, persist, clear and serial gating
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i || clr_gate);

	sequence s_up;
		cs_hi && up_fall && !filt[`DSS_P_DN];
	endsequence
	sequence s_dn;
		cs_hi && dn_fall && !filt[`DSS_P_UP];
	endsequence
	sequence s_cfg_wr;
		data_wr && ptr == `DSS_A_CFG;
	endsequence

	step_up_a: assert property (s_up ##0 gran == `DSS_GR_12 |=>
		dac == $past(dac) + 12'h001) else $error("12-bit step up wrong");
	step_ten_a: assert property (s_up ##0 gran == `DSS_GR_10 |=>
		dac[1:0] == $past(dac[1:0]) &&
		dac[11:2] == $past(dac[11:2]) + 10'h001)
		else $error("10-bit step up wrong");
	step_eight_dn_a: assert property (s_dn ##0 gran == `DSS_GR_8 |=>
		dac[3:0] == $past(dac[3:0]) &&
		dac[11:4] == $past(dac[11:4]) - 8'h01)
		else $error("8-bit step down wrong");
	reserved_hold_a: assert property ((s_up or s_dn) ##0
		gran == `DSS_GR_RSV |=> $stable(dac))
		else $error("reserved granularity stepped");
	cs_low_ignore_a: assert property (!cs_hi && !dac_wr_vol |=>
		$stable(dac)) else $error("step pins acted with select low");
	span_cfg_a: assert property (s_cfg_wr |=> cfg == $past(rx_byte)
		##1 fs_q.int_en == (cfg[`DSS_FS_MSB:`DSS_FS_LSB] != `DSS_SEL_EXT))
		else $error("span not taken from config");
	zero_low_a: assert property (s_cfg_wr ##0
		rx_byte[`DSS_ZS_MSB:`DSS_ZS_LSB] == `DSS_SEL_ZS_LOW |-> ##2
		zs_q.level_mv == `DSS_ZS_LOW_MV && zs_q.int_en)
		else $error("zero scale low level wrong");
	ready_drop_a: assert property (!filt[`DSS_P_SUP] |=>
		not_ready && !ready_n_oe_o) else $error("ready kept on supply drop");
	ready_delay_a: assert property ($fell(not_ready) |->
		$past(rdy_cnt) == CW'(RDY_CYCLES - 1) && filt[`DSS_P_SUP])
		else $error("ready delay wrong");
	persist_set_a: assert property (data_wr && ptr == `DSS_A_PERSIST &&
		rx_byte == `DSS_PERSIST_SET |=> persist_target_sel [*2])
		else $error("persist bit not set");
	spi_gate_a: assert property (!spi_on |=> $stable(shreg))
		else $error("serial sampled while gated");
	clr_zero_a: assert property (@(posedge clock_i)
		disable iff (!resetn_i) clr_gate ##1 clr_gate |->
		dac == `DSS_DAC_ZERO && shreg == 8'h00)
		else $error("clear did not zero registers");

endmodule : dss_span_step

// *** include/dss_cfg.svh ***
/*
 * Constants of the DAC span and step control: register offsets, field
 * positions, decode values, synchroniser pin indices and timing figures.
 * Assumes it is included by bare name from the design and the bench.
 */
`ifndef DSS_CFG_SVH
`define DSS_CFG_SVH
`define DSS_A_DAC_HI    6'h38
`define DSS_A_DAC_LO    6'h39
`define DSS_A_CFG       6'h3C
`define DSS_A_PERSIST   6'h3F
`define DSS_PERSIST_SET 8'h80
`define DSS_PERSIST_CLR 8'h00
`define DSS_CFG_RESET   8'h00
`define DSS_FS_MSB      7
`define DSS_FS_LSB      5
`define DSS_ZS_MSB      4
`define DSS_ZS_LSB      2
`define DSS_GR_MSB      1
`define DSS_GR_LSB      0
`define DSS_SEL_EXT     3'h0
`define DSS_SEL_ZS_LOW  3'h1
`define DSS_SEL_MAX     3'h5
`define DSS_STEP_MV     12'h25D
`define DSS_ZS_LOW_MV   12'h097
`define DSS_GR_12       2'h0
`define DSS_GR_10       2'h1
`define DSS_GR_8        2'h2
`define DSS_GR_RSV      2'h3
`define DSS_STEP_12     12'h001
`define DSS_STEP_10     12'h004
`define DSS_STEP_8      12'h010
`define DSS_DAC_ZERO    12'h000
`define DSS_BIT_LAST    3'h7
`define DSS_P_CS        0
`define DSS_P_SCK       1
`define DSS_P_SI        2
`define DSS_P_UP        3
`define DSS_P_DN        4
`define DSS_P_OE        5
`define DSS_P_SUP       6
`define DSS_NPIN        7
`define DSS_PIN_IDLE    7'h01
`define DSS_RDY_DELAY_US 100
`define DSS_CLK_HZ      40000000
`define DSS_HZ_PER_MHZ  1000000
`endif

// *** include/dss_pkg.sv ***
/*
 * Types of the DAC span and step control.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dss_pkg;
	// Serial framing phase
	typedef enum logic [1:0] {SP_ID, SP_ADDR, SP_DATA, SP_SKIP} dss_spi_e;
	// One reference scale as seen by the analog side
	typedef struct packed {
		logic        int_en;   // Internal source drives the pin
		logic [11:0] level_mv; // Selected level in millivolts
	} dss_scale_s;
endpackage : dss_pkg

// *** test/dss_master_model.sv ***
/*
 * SPI master and step-pin controller standing outside the span block.
 * Assumes clock_i is the block clock; the bench calls the tasks.
 */
`timescale 1ns/1ps
module dss_master_model (
	input  wire logic clock_i, // Block clock
	input  wire logic so_i,    // Serial data from block
	output logic      cs_n_o,  // Chip select, low
	output logic      sck_o,   // Serial clock
	output logic      si_o,    // Serial data to block
	output logic      up_o,    // Step up pin
	output logic      down_o   // Step down pin
);
	// Idle levels; serial clock stands low outside frames
	initial begin
		cs_n_o = 1'b1;
		sck_o  = 1'b0;
		si_o   = 1'b0;
		up_o   = 1'b0;
		down_o = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask : tick

	task automatic hold_select(input logic v);
		cs_n_o <= v;
	endtask : hold_select

	task automatic frame(input logic [31:0] bits, input int nb,
		output logic [15:0] rd);
		rd = '0;
		cs_n_o <= 1'b0;
		tick(4);
		for (int i = nb - 1; i >= 0; i--) begin
			sck_o <= 1'b0;
			si_o  <= bits[i];
			tick(4);
			sck_o <= 1'b1;
			tick(4);
			rd = {rd[14:0], so_i}; // Bit shifted at last fall
		end
		sck_o <= 1'b0;
		tick(4);
		cs_n_o <= 1'b1;
		si_o   <= ~si_o; // Line no longer meaningful
		tick(8);
	endtask : frame

	// Other pin low at fall unless bad
	task automatic step(input logic dn, input logic bad);
		up_o   <= ~dn | bad;
		down_o <= dn | bad;
		tick(40);
		if (bad) begin
			down_o <= 1'b0; // Falls while up is high
			tick(40);
		end
		up_o   <= 1'b0;
		down_o <= 1'b0;
		tick(40);
	endtask : step
endmodule : dss_master_model

// *** test/dss_span_step_tb_top.sv ***
/*
 * Self-checking bench for the span and step control block.
 * Assumes the master model file and the shared package are compiled.
 */
`timescale 1ns/1ps
`include "dss_cfg.svh"
module dss_span_step_tb_top;
	import dss_pkg::*;
	logic        clock_i, resetn_i, so_o, so_oe_o, so_w;
	logic        cs_n, sck, si, up, down, clr, buf_oe, sup_ok;
	logic        ready_n_o, ready_n_oe_o, nv_write_o, buffer_drive_o;
	logic [5:0]  nv_addr_o;
	logic [7:0]  nv_data_o;
	logic [11:0] dac_code_o;
	dss_scale_s  fs, zs;
	logic [15:0] rd;
	int          n_errors, num_checks, n_nvw, cyc;

	assign so_w = so_oe_o ? so_o : 1'bz;

	dss_span_step #(.RDY_CYCLES(8)) dss_span_step_i (
		.clock_i(clock_i), .resetn_i(resetn_i), .cs_n_i(cs_n),
		.sck_i(sck), .si_i(si), .so_o(so_o), .so_oe_o(so_oe_o),
		.up_i(up), .down_i(down), .async_zero_pin_i(clr),
		.buf_oe_i(buf_oe), .supply_ok_i(sup_ok), .ready_n_o(ready_n_o),
		.ready_n_oe_o(ready_n_oe_o), .nv_image_i(8'h84),
		.nv_write_o(nv_write_o), .nv_addr_o(nv_addr_o),
		.nv_data_o(nv_data_o), .dac_code_o(dac_code_o),
		.full_scale_level_o(fs), .zero_scale_level_o(zs),
		.buffer_drive_o(buffer_drive_o));

	dss_master_model dss_master_model_i (
		.clock_i(clock_i), .so_i(so_w), .cs_n_o(cs_n), .sck_o(sck),
		.si_o(si), .up_o(up), .down_o(down));

	// Clock of 25 ns
	initial begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end

	task automatic tally_and_finish;
		$display("Checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish

	// Storage pulse counter and hang limit
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (nv_write_o === 1'b1)
			n_nvw <= n_nvw + 1;
		if (cyc == 40000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	task automatic check(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask : tick

	task automatic wr(input logic [7:0] a, d);
		dss_master_model_i.frame({8'h00, 8'h80, a, d}, 24, rd);
	endtask : wr

	task automatic wr_dac(input logic [11:0] c);
		dss_master_model_i.frame({16'h8038, c, 4'h0}, 32, rd);
	endtask : wr_dac

	task automatic rd2(input logic [7:0] a);
		dss_master_model_i.frame({8'h81, a, 16'h0000}, 32, rd);
	endtask : rd2

	task automatic wait_ready;
		for (int i = 0; i < 200 && ready_n_oe_o !== 1'b1; i++)
			tick(1);
		check("ready", ready_n_oe_o, 1'b1);
		check("rdylvl", ready_n_o, 1'b0);
	endtask : wait_ready

	task automatic t_boot;
		wait_ready();
		check("dac", dac_code_o, 12'h000);
		check("fs", fs, {1'b1, 12'd2420});
		check("zs", zs, {1'b1, 12'd151});
		rd2(8'h3C);
		check("cfg", rd[15:8], 8'h84);
		rd2(8'h3F);
		check("persist", rd[15:8], 8'h00);
		check("sooe", so_oe_o, 1'b0);
		$display("done t_boot");
	endtask : t_boot

	task automatic t_span;
		int n0;
		logic [11:0] f, z;
		for (int c = 0; c < 6; c++) begin
			n0 = n_nvw;
			wr(8'h3C, {c[2:0], c[2:0], 2'b00});
			tick(4);
			f = 12'(c * 605);
			z = (c == 1) ? 12'd151 : 12'(c * 605 - 605);
			check("nvw", n_nvw - n0, 1);
			check("nvaddr", nv_addr_o, 6'h3C);
			check("nvdata", nv_data_o, {c[2:0], c[2:0], 2'b00});
			check("fsen", fs.int_en, c != 0);
			check("zsen", zs.int_en, c != 0);
			if (c != 0) begin
				check("fsmv", fs.level_mv, f);
				check("zsmv", zs.level_mv, z);
			end
		end
		$display("done t_span");
	endtask : t_span

	task automatic t_step;
		logic [11:0] st;
		for (int g = 0; g < 4; g++) begin
			wr(8'h3C, 8'hA4 | g[7:0]);
			wr_dac(12'h89E);
			st = (g == 3) ? 12'h000 : 12'h001 << (2 * g);
			dss_master_model_i.step(1'b0, 1'b0);
			dss_master_model_i.step(1'b0, 1'b0);
			dss_master_model_i.step(1'b1, 1'b0);
			check("step", dac_code_o, 12'h89E + st);
			dss_master_model_i.step(1'b1, 1'b0);
			check("down", dac_code_o, 12'h89E);
			dss_master_model_i.step(1'b0, 1'b1);
			check("bad", dac_code_o, 12'h89E + st);
		end
		wr(8'h3C, 8'hA4);
		dss_master_model_i.hold_select(1'b0);
		dss_master_model_i.step(1'b0, 1'b0);
		dss_master_model_i.hold_select(1'b1);
		tick(8);
		check("cslow", dac_code_o, 12'h89E);
		$display("done t_step");
	endtask : t_step

	task automatic t_dac;
		int n0;
		wr_dac(12'hABC);
		check("dacwr", dac_code_o, 12'hABC);
		rd2(8'h38);
		check("dacrd", rd, 16'hABC0);
		wr(8'h3F, 8'h80);
		rd2(8'h3F);
		check("pset", rd[15:8], 8'h80);
		n0 = n_nvw;
		wr_dac(12'h123);
		check("pdac", dac_code_o, 12'hABC);
		check("pnvw", n_nvw > n0, 1'b1);
		wr(8'h3F, 8'h00);
		// Address outside the map must leave config alone
		n0 = n_nvw;
		wr(8'h7C, 8'h00);
		check("skipnvw", n_nvw - n0, 0);
		check("skipfs", fs, {1'b1, 12'd3025});
		clr <= 1'b1;
		tick(2);
		check("clr", dac_code_o, 12'h000);
		clr <= 1'b0;
		tick(2);
		$display("done t_dac");
	endtask : t_dac

	task automatic t_power;
		dss_master_model_i.step(1'b0, 1'b0);
		sup_ok <= 1'b0;
		tick(10);
		check("notrdy", ready_n_oe_o, 1'b0);
		clr <= 1'b1;
		tick(4);
		check("clrign", dac_code_o, 12'h001);
		clr <= 1'b0;
		sup_ok <= 1'b1;
		wait_ready();
		buf_oe <= 1'b0;
		tick(8);
		check("boff", buffer_drive_o, 1'b0);
		buf_oe <= 1'b1;
		tick(8);
		check("bon", buffer_drive_o, 1'b1);
		$display("done t_power");
	endtask : t_power

	// Reset, then scenarios in turn
	initial begin
		resetn_i = 1'b0;
		clr = 1'b0;
		buf_oe = 1'b1;
		sup_ok = 1'b1;
		tick(20);
		resetn_i <= 1'b1;
		t_boot();
		t_span();
		t_step();
		t_dac();
		t_power();
		tally_and_finish();
	end
endmodule : dss_span_step_tb_top
